// ==== rtl/gsc_ctl_pkg.sv ====
// Constants and types for the serial channel backoff and receive control.
// Assumes register indices are word indices on APB: byte address = 4 * index.
package gsc_ctl_pkg;

  // ==========================================================
  // Register indices
  localparam logic [7:0] IDX_MODE    = 8'h84;
  localparam logic [7:0] IDX_OPTIONS = 8'h87;
  localparam logic [7:0] IDX_IFS     = 8'ha4;
  localparam logic [7:0] IDX_RAND    = 8'he4;
  localparam logic [7:0] IDX_RECEIVER_STATUS   = 8'he8;
  localparam logic [7:0] IDX_FIFO    = 8'hf4;
  localparam logic [7:0] IDX_SLOT    = 8'hf5;

  // ==========================================================
  // Field positions
  localparam int MODE_SDLC     = 0;
  localparam int MODE_BK_LO    = 5;
  localparam int OPT_AUX_RX    = 4;
  localparam int OPT_EXT_RXCLK = 3;
  localparam int OPT_IDLE_FLAG = 2;
  localparam int SLOT_DETERM   = 6;
  localparam int SLOT_JAM_DC   = 7;
  localparam int RS_HW_ACK     = 0;
  localparam int RS_RX_EN      = 1;
  localparam int RS_NOT_EMPTY  = 2;
  localparam int RS_DONE       = 3;
  localparam int RS_CRC        = 4;
  localparam int RS_ALIGN      = 5;
  localparam int RS_ABORT      = 6;
  localparam int RS_OVERRUN    = 7;

  // ==========================================================
  // Values
  localparam logic [1:0] BACKOFF_ALT  = 2'b11;
  localparam logic [7:0] RAND_FROZEN  = 8'hff;
  localparam logic [7:0] RAND_RESET   = 8'h01;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [1:0] FIFO_DEPTH   = 2'h3;
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam int         PIN_COUNT    = 5;

  typedef enum logic [1:0] {IFS_IDLE, IFS_FIRST, IFS_SECOND} ifs_state_t;

  typedef struct packed {
    logic frame_end;
    logic crc_err;
    logic align_err;
    logic abort;
  } rx_events_t;

endpackage

// ==== rtl/gsc_backoff_rx_ctl.sv ====
// Backoff, interframe spacing and receive control of the serial channel.
// Assumes an APB master, framing logic on pclk and asynchronous line pins.
//
// Summary of operation
// - INTERFRAME_SPACING write value is halved into the upper seven bits.
// - One gap is two full countdowns of the seven-bit spacing value.
// - INTERFRAME_SPACING read shows live count above, LSB 1 first pass, 0 second.
// - Slot field bits 5..0 give slot address and priority, 63 highest.
// - Slot address zero forbids transmit during collision resolution.
// - Slot bit 6 selects deterministic collision resolution.
// - Deterministic mode stops carrier return from restarting the spacing.
// - Slot bit 7 selects DC jam when 1, AC jam when 0.
// - Random backoff value comes from a free running feedback shifter.
// - Writing all ones freezes the shifter; other values restart it.
// - Auxiliary receive enable allows back-to-back SDLC frames only.
// - External receive clock bit selects the external receive clock.
// - Idle flag enable sends idle flags between SDLC frames only.
// - Receive FIFO holds three bytes, oldest first, loaded per byte.
// - Status bit 0 enables hardware acknowledge.
// - Status bit 1 enables reception; setting it flushes the FIFO.
// - Setting receive enable clears done, CRC, alignment, abort flags.
// - Not-empty status follows a FIFO read within twelve cycles.
// - Hardware clears receive enable on error, or at frame end unless SDLC auxiliary receive is on.
// - In CSMA mode the receive pin is watched regardless of enable.
// - Protocol bit 1 selects SDLC, 0 selects CSMA/CD.
// - Alternate backoff waits until the interframe spacing ends.
// - Not-empty is set while data is held, cleared when drained.
`timescale 1ns/1ps

module gsc_backoff_rx_ctl (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    tx_bit_clk,
  input  wire logic                    rx_clk_int,
  input  wire logic                    rx_clk_ext,
  input  wire logic                    rx_data_pin,
  input  wire logic                    carrier_pin,
  input  wire logic                    tx_frame_done,
  input  wire gsc_ctl_pkg::rx_events_t rx_events,
  output logic                         ifs_busy,
  output logic                         backoff_permit,
  output logic                         jam_dc,
  output logic                         deterministic_mode,
  output logic      [5:0]              slot_address,
  output logic                         resolution_tx_permit,
  output logic                         sdlc_mode,
  output logic                         idle_flags_on,
  output logic                         aux_rx_on,
  output logic                         hw_ack_on,
  output logic                         collision_watch,
  output logic      [7:0]              random_value
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Pin synchronisers
  logic [4:0] pin_raw;
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] pin_last;

  assign pin_raw = {carrier_pin, rx_data_pin, rx_clk_ext, rx_clk_int, tx_bit_clk};

  // Every pin takes three flops; edges are found from the second and third only
  for (genvar i = 0; i < gsc_ctl_pkg::PIN_COUNT; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_meta[i] <= 1'b0;
        pin_sync[i] <= 1'b0;
        pin_last[i] <= 1'b0;
      end else begin
        pin_meta[i] <= pin_raw[i];
        pin_sync[i] <= pin_meta[i];
        pin_last[i] <= pin_sync[i];
      end
    end
  end

  wire pin_rise_tx  = pin_sync[0] & ~pin_last[0];
  wire pin_rise_ri  = pin_sync[1] & ~pin_last[1];
  wire pin_rise_re  = pin_sync[2] & ~pin_last[2];
  wire rx_line      = pin_sync[3];
  wire rx_line_edge = pin_sync[3] ^ pin_last[3];
  wire carrier_rise = pin_sync[4] & ~pin_last[4];

  // ==========================================================
  // APB decode
  logic [7:0] mode_reg;
  logic [7:0] opt_reg;
  logic [6:0] ifs_reload;
  logic [6:0] ifs_count;
  logic [7:0] rand_reg;
  logic [7:0] slot_reg;
  logic       hw_ack;
  logic       rx_enable;
  logic       flag_done;
  logic       flag_crc;
  logic       flag_align;
  logic       flag_abort;
  logic       flag_overrun;
  logic [1:0] fifo_count;
  logic [1:0] fifo_rd_ptr;
  logic [1:0] fifo_wr_ptr;
  logic [7:0] fifo_mem [0:2];
  gsc_ctl_pkg::ifs_state_t ifs_state;

  wire [7:0] reg_idx    = paddr[9:2];
  wire       aligned    = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  wire       hit_mode   = aligned && (reg_idx == gsc_ctl_pkg::IDX_MODE);
  wire       hit_opt    = aligned && (reg_idx == gsc_ctl_pkg::IDX_OPTIONS);
  wire       hit_ifs    = aligned && (reg_idx == gsc_ctl_pkg::IDX_IFS);
  wire       hit_rand   = aligned && (reg_idx == gsc_ctl_pkg::IDX_RAND);
  wire       hit_receiver_status  = aligned && (reg_idx == gsc_ctl_pkg::IDX_RECEIVER_STATUS);
  wire       hit_fifo   = aligned && (reg_idx == gsc_ctl_pkg::IDX_FIFO);
  wire       hit_slot   = aligned && (reg_idx == gsc_ctl_pkg::IDX_SLOT);
  wire       mapped     = hit_mode | hit_opt | hit_ifs | hit_rand | hit_receiver_status
                          | hit_fifo | hit_slot;
  wire       access     = psel & penable;
  wire       first_acc  = access & ~pready;
  wire       xfer_done  = access & pready;
  wire       wr_xfer    = xfer_done & pwrite;
  wire       rd_xfer    = xfer_done & ~pwrite;
  wire       wr_ifs     = wr_xfer & hit_ifs;
  wire       wr_rand    = wr_xfer & hit_rand;
  wire       wr_receiver_status   = wr_xfer & hit_receiver_status;
  wire       rx_en_set  = wr_receiver_status & pwdata[gsc_ctl_pkg::RS_RX_EN];
  wire       ovr_clear  = wr_receiver_status & ~pwdata[gsc_ctl_pkg::RS_OVERRUN];

  wire       is_sdlc    = mode_reg[gsc_ctl_pkg::MODE_SDLC];
  wire       alt_bk     = mode_reg[gsc_ctl_pkg::MODE_BK_LO +: 2] == gsc_ctl_pkg::BACKOFF_ALT;
  wire       determ     = slot_reg[gsc_ctl_pkg::SLOT_DETERM];
  wire       not_empty  = fifo_count != 2'h0;
  wire       ifs_first  = ifs_state == gsc_ctl_pkg::IFS_FIRST;

  // Spacing read: live count plus pass marker
  wire [7:0] ifs_read   = {ifs_count, ifs_first};
  wire [7:0] receiver_status_read = {flag_overrun, flag_abort, flag_align, flag_crc,
                           flag_done, not_empty, rx_enable, hw_ack};
  wire [7:0] rd_word    = hit_mode  ? mode_reg :
                          hit_opt   ? opt_reg :
                          hit_ifs   ? ifs_read :
                          hit_rand  ? rand_reg :
                          hit_receiver_status ? receiver_status_read :
                          hit_fifo  ? fifo_mem[fifo_rd_ptr] :
                          hit_slot  ? slot_reg : 8'h00;

  // One wait state: data is captured on the same edge that raises pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= first_acc;
      pslverr <= first_acc & ~mapped;
      if (first_acc && !pwrite) begin
        prdata <= {24'h00_0000, rd_word};
      end
    end
  end

  // ==========================================================
  // Plain control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg   <= gsc_ctl_pkg::REG_RESET;
      opt_reg    <= gsc_ctl_pkg::REG_RESET;
      slot_reg   <= gsc_ctl_pkg::REG_RESET;
      ifs_reload <= 7'h00;
      hw_ack     <= 1'b0;
    end else if (wr_xfer) begin
      if (hit_mode) begin
        mode_reg <= pwdata[7:0];
      end
      if (hit_opt) begin
        opt_reg <= pwdata[7:0];
      end
      if (hit_slot) begin
        slot_reg <= pwdata[7:0];
      end
      if (hit_ifs) begin
        ifs_reload <= pwdata[7:1];
      end
      if (hit_receiver_status) begin
        hw_ack <= pwdata[gsc_ctl_pkg::RS_HW_ACK];
      end
    end
  end

  // ==========================================================
  // Interframe spacing
  // The counter lives on pclk and steps on synchronised bit clock edges,
  // so a read never sees a half-updated value, only a late one.
  wire ifs_tick    = pin_rise_tx;
  wire ifs_end     = ifs_count[6:1] == 6'h00;
  wire ifs_restart = carrier_rise & ~determ
                     & (ifs_state != gsc_ctl_pkg::IFS_IDLE);
  wire ifs_start   = tx_frame_done | ifs_restart;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifs_state <= gsc_ctl_pkg::IFS_IDLE;
      ifs_count <= 7'h00;
    end else if (ifs_start) begin
      ifs_state <= gsc_ctl_pkg::IFS_FIRST;
      ifs_count <= ifs_reload;
    end else if (ifs_tick) begin
      unique case (ifs_state)
        gsc_ctl_pkg::IFS_IDLE: begin
          ifs_count <= ifs_count;
        end
        gsc_ctl_pkg::IFS_FIRST: begin
          // Second pass reloads the same value
          ifs_state <= ifs_end ? gsc_ctl_pkg::IFS_SECOND : ifs_state;
          ifs_count <= ifs_end ? ifs_reload : ifs_count - 7'h01;
        end
        gsc_ctl_pkg::IFS_SECOND: begin
          ifs_state <= ifs_end ? gsc_ctl_pkg::IFS_IDLE : ifs_state;
          ifs_count <= ifs_end ? 7'h00 : ifs_count - 7'h01;
        end
      endcase
    end
  end

  // ==========================================================
  // Random backoff source
  // XNOR feedback locks only at all ones, so freeze needs no extra flag
  wire       rand_fb   = ~(rand_reg[7] ^ rand_reg[5] ^ rand_reg[4] ^ rand_reg[3]);
  wire       rand_hold = rand_reg == gsc_ctl_pkg::RAND_FROZEN;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rand_reg <= gsc_ctl_pkg::RAND_RESET;
    end else if (wr_rand) begin
      rand_reg <= pwdata[7:0];
    end else if (!rand_hold) begin
      rand_reg <= {rand_reg[6:0], rand_fb};
    end
  end

  // ==========================================================
  // Receive byte assembly
  logic [7:0] rx_shift;
  logic [2:0] rx_bits;

  wire rx_edge    = opt_reg[gsc_ctl_pkg::OPT_EXT_RXCLK] ? pin_rise_re
                                                        : pin_rise_ri;
  wire rx_sample  = rx_edge & rx_enable;
  wire byte_ready = rx_sample & (rx_bits == gsc_ctl_pkg::LAST_BIT);
  wire fifo_full  = fifo_count == gsc_ctl_pkg::FIFO_DEPTH;
  wire fifo_push  = byte_ready & ~fifo_full & ~rx_en_set;
  wire ovr_event  = byte_ready & fifo_full;
  wire fifo_pop   = rd_xfer & hit_fifo & not_empty & ~rx_en_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift <= 8'h00;
      rx_bits  <= 3'h0;
    end else if (!rx_enable) begin
      rx_bits <= 3'h0;
    end else if (rx_sample) begin
      rx_shift <= {rx_line, rx_shift[7:1]};
      rx_bits  <= rx_bits + 3'h1;
    end
  end

  // ==========================================================
  // Receive FIFO, three entries, oldest at the read port
  function automatic logic [1:0] ptr_inc(input logic [1:0] p);
    ptr_inc = (p == 2'h2) ? 2'h0 : p + 2'h1;
  endfunction

  always_ff @(posedge pclk) begin
    if (fifo_push) begin
      fifo_mem[fifo_wr_ptr] <= {rx_line, rx_shift[7:1]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_count  <= 2'h0;
      fifo_rd_ptr <= 2'h0;
      fifo_wr_ptr <= 2'h0;
    end else if (rx_en_set) begin
      fifo_count  <= 2'h0;
      fifo_rd_ptr <= 2'h0;
      fifo_wr_ptr <= 2'h0;
    end else begin
      if (fifo_push) begin
        fifo_wr_ptr <= ptr_inc(fifo_wr_ptr);
      end
      if (fifo_pop) begin
        fifo_rd_ptr <= ptr_inc(fifo_rd_ptr);
      end
      // Count updates the very next cycle, well inside the limit
      fifo_count <= fifo_count + {1'b0, fifo_push} - {1'b0, fifo_pop};
    end
  end

  // ==========================================================
  // Receive status and enable
  wire any_err  = rx_events.crc_err | rx_events.align_err | rx_events.abort | ovr_event;
  wire done_evt = rx_events.frame_end & ~any_err;
  // In SDLC with auxiliary receive the enable survives a clean frame end
  wire keep_on  = is_sdlc & opt_reg[gsc_ctl_pkg::OPT_AUX_RX];
  wire hw_stop  = (rx_events.frame_end & ~keep_on) | any_err;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_enable <= 1'b0;
    end else if (wr_receiver_status) begin
      // A software write wins over a hardware stop in the same cycle
      rx_enable <= pwdata[gsc_ctl_pkg::RS_RX_EN];
    end else if (hw_stop) begin
      rx_enable <= 1'b0;
    end
  end

  // Hardware sets win over clears in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_done    <= 1'b0;
      flag_crc     <= 1'b0;
      flag_align   <= 1'b0;
      flag_abort   <= 1'b0;
      flag_overrun <= 1'b0;
    end else begin
      flag_done    <= done_evt | (flag_done & ~rx_en_set);
      flag_crc     <= rx_events.crc_err | (flag_crc & ~rx_en_set);
      flag_align   <= rx_events.align_err | (flag_align & ~rx_en_set);
      flag_abort   <= rx_events.abort | (flag_abort & ~rx_en_set);
      flag_overrun <= ovr_event | (flag_overrun & ~ovr_clear);
    end
  end

  // ==========================================================
  // Registered control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifs_busy             <= 1'b0;
      backoff_permit       <= 1'b1;
      jam_dc               <= 1'b0;
      deterministic_mode   <= 1'b0;
      slot_address         <= 6'h00;
      resolution_tx_permit <= 1'b0;
      sdlc_mode            <= 1'b0;
      idle_flags_on        <= 1'b0;
      aux_rx_on            <= 1'b0;
      hw_ack_on            <= 1'b0;
      collision_watch      <= 1'b0;
      random_value         <= gsc_ctl_pkg::RAND_RESET;
    end else begin
      ifs_busy             <= ifs_state != gsc_ctl_pkg::IFS_IDLE;
      backoff_permit       <= ~alt_bk | (ifs_state == gsc_ctl_pkg::IFS_IDLE);
      jam_dc               <= slot_reg[gsc_ctl_pkg::SLOT_JAM_DC];
      deterministic_mode   <= determ;
      slot_address         <= slot_reg[5:0];
      resolution_tx_permit <= slot_reg[5:0] != 6'h00;
      sdlc_mode            <= is_sdlc;
      idle_flags_on        <= is_sdlc & opt_reg[gsc_ctl_pkg::OPT_IDLE_FLAG];
      aux_rx_on            <= keep_on;
      hw_ack_on            <= hw_ack;
      collision_watch      <= ~is_sdlc & rx_line_edge;
      random_value         <= rand_reg;
    end
  end

  // ==========================================================
  // Assertions
  sequence s_last_pass_end;
    (ifs_state == gsc_ctl_pkg::IFS_SECOND) && ifs_tick && ifs_end && !ifs_start;
  endsequence

  sequence s_pop_last;
    fifo_pop && (fifo_count == 2'h1) && !fifo_push;
  endsequence

  AST_IFS_HALF: assert property (wr_ifs |=> ifs_reload == $past(pwdata[7:1]))
    else $error("spacing value not halved");

  AST_IFS_TWO_PASS: assert property (
    (ifs_first && ifs_tick && ifs_end && !ifs_start)
      |=> (ifs_state == gsc_ctl_pkg::IFS_SECOND) && (ifs_count == $past(ifs_reload)))
    else $error("second pass not entered");

  AST_IFS_DONE: assert property (s_last_pass_end |=> ##1 !ifs_busy)
    else $error("gap not ended after second pass");

  AST_IFS_READ: assert property (
    (first_acc && !pwrite && hit_ifs) |=> prdata[7:0] == $past(ifs_read))
    else $error("spacing read wrong");

  AST_SLOT_ZERO: assert property (
    $stable(slot_reg) [*2] |-> resolution_tx_permit == (slot_reg[5:0] != 6'h00))
    else $error("slot zero permit wrong");

  AST_NO_RESTART: assert property (
    (determ && carrier_rise && !tx_frame_done && !ifs_tick
      && ifs_state == gsc_ctl_pkg::IFS_SECOND) |=> ifs_state == gsc_ctl_pkg::IFS_SECOND)
    else $error("spacing restarted in deterministic mode");

  AST_JAM: assert property (##1 jam_dc == $past(slot_reg[7]))
    else $error("jam type wrong");

  AST_RAND_RUN: assert property (
    (!rand_hold && !wr_rand) |=> rand_reg != $past(rand_reg))
    else $error("random source stalled");

  AST_RAND_FREEZE: assert property ((rand_hold && !wr_rand) |=> rand_hold)
    else $error("frozen random source moved");

  AST_FLUSH: assert property ((rx_en_set && !done_evt) |=> !not_empty && !flag_done)
    else $error("enable did not flush");

  AST_FLAG_CLR: assert property (
    (rx_en_set && !rx_events.crc_err && !rx_events.abort) |=> !flag_crc && !flag_abort)
    else $error("status flags not cleared");

  AST_NE_UPDATE: assert property (s_pop_last |-> ##[1:12] !receiver_status_read[2])
    else $error("not-empty not updated");

  AST_HW_STOP: assert property ((hw_stop && !wr_receiver_status) |=> !rx_enable)
    else $error("receive enable not cleared");

  AST_BACKOFF: assert property (
    (alt_bk && ifs_busy) [*2] |-> !backoff_permit)
    else $error("backoff not held by spacing");

endmodule

// ==== bench/remote_station.sv ====
// Remote station model driving the serial line pins of the channel.
// Assumes the caller waits on its tasks; clocks stand still between frames.
`timescale 1ns/1ps

module remote_station (
  output logic rx_clk_int,
  output logic rx_clk_ext,
  output logic rx_data_pin,
  output logic tx_bit_clk,
  output logic carrier_pin
);
  // ==========================================================
  // Line state
  initial begin
    rx_clk_int  = 1'b0;
    rx_clk_ext  = 1'b0;
    rx_data_pin = 1'b1;
    tx_bit_clk  = 1'b0;
    carrier_pin = 1'b0;
  end

  // ==========================================================
  // One byte, first bit is bit 0, 80 ns bit time, on either receive clock
  // Pins move 2 ns off the bench clock edge
  task automatic send(input logic [7:0] b, input logic ext);
    #2;
    for (int i = 0; i < 8; i++) begin
      rx_data_pin = b[i];
      #40;
      if (ext) rx_clk_ext = 1'b1;
      else rx_clk_int = 1'b1;
      #40;
      rx_clk_ext = 1'b0;
      rx_clk_int = 1'b0;
    end
    // Released line must not keep the last bit
    rx_data_pin = ~b[7];
  endtask

  // Bit times on the transmit clock
  task automatic bits(input int n);
    #2;
    repeat (n) begin
      #40 tx_bit_clk = 1'b1;
      #40 tx_bit_clk = 1'b0;
    end
  endtask

  // Carrier returns for one bit time
  task automatic carrier();
    #2;
    carrier_pin = 1'b1;
    #80;
    carrier_pin = 1'b0;
  endtask
endmodule

// ==== bench/serial_channel_backoff_receive_ctl_bench.sv ====
// Self-checking bench of the backoff and receive control block.
// Assumes the remote station model drives the line pins asynchronously.
`timescale 1ns/1ps

module serial_channel_backoff_receive_ctl_bench;
  logic                    pclk = 0;
  logic                    presetn = 0;
  logic                    psel = 0;
  logic                    penable = 0;
  logic                    pwrite = 0;
  logic [11:0]             paddr = 0;
  logic [31:0]             pwdata = 0;
  logic                    tx_frame_done = 0;
  gsc_ctl_pkg::rx_events_t rx_events = '0;
  logic [31:0]             prdata;
  logic                    pready, pslverr, lerr;
  logic                    ifs_busy, backoff_permit, jam_dc, deterministic_mode;
  logic                    resolution_tx_permit, sdlc_mode, idle_flags_on, aux_rx_on;
  logic                    hw_ack_on, collision_watch;
  logic [5:0]              slot_address;
  logic [7:0]              random_value, q, r;
  wire                     rx_clk_int, rx_clk_ext, rx_data_pin, tx_bit_clk, carrier_pin;
  int                      error_cnt = 0;
  int                      cmp_count = 0;
  int                      hits = 0;
  localparam logic [7:0]   slot_vals [3] = '{8'hc0, 8'h3f, 8'h81};

  always #5 pclk = ~pclk;
  always @(posedge pclk) if (collision_watch === 1'b1) hits <= hits + 1;

  gsc_backoff_rx_ctl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tx_bit_clk, .rx_clk_int, .rx_clk_ext, .rx_data_pin,
    .carrier_pin, .tx_frame_done, .rx_events, .ifs_busy, .backoff_permit, .jam_dc,
    .deterministic_mode, .slot_address, .resolution_tx_permit, .sdlc_mode,
    .idle_flags_on, .aux_rx_on, .hw_ack_on, .collision_watch, .random_value);
  remote_station station (.rx_clk_int, .rx_clk_ext, .rx_data_pin, .tx_bit_clk, .carrier_pin);

  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata[7:0];
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", {7'h0, n < 40}, 8'h01);
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] i, input logic [7:0] e);
    xfer(1'b0, i, 8'h00);
    chk(nm, q, e);
  endtask
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_slot();
    rd("slot_rst", gsc_ctl_pkg::IDX_SLOT, gsc_ctl_pkg::REG_RESET);
    foreach (slot_vals[k]) begin
      wr(gsc_ctl_pkg::IDX_SLOT, slot_vals[k]);
      rd("slot", gsc_ctl_pkg::IDX_SLOT, slot_vals[k]);
      chk("slot_addr", {2'b00, slot_address}, {2'b00, slot_vals[k][5:0]});
      chk("tx_permit", {7'h0, resolution_tx_permit}, {7'h0, |slot_vals[k][5:0]});
      chk("determ", {7'h0, deterministic_mode}, {7'h0, slot_vals[k][6]});
      chk("jam_dc", {7'h0, jam_dc}, {7'h0, slot_vals[k][7]});
    end
    xfer(1'b0, 8'h10, 8'h00);
    chk("unmapped", {7'h0, lerr}, 8'h01);
  endtask
  task automatic t_modes();
    wr(gsc_ctl_pkg::IDX_OPTIONS, 8'h14);
    for (int m = 1; m >= 0; m--) begin
      wr(gsc_ctl_pkg::IDX_MODE, 8'(m));
      wt(1);
      chk("sdlc", {7'h0, sdlc_mode}, 8'(m));
      chk("idle_flags", {7'h0, idle_flags_on}, 8'(m));
      chk("aux_rx", {7'h0, aux_rx_on}, 8'(m));
    end
  endtask
  task automatic t_ifs();
    // Alternate backoff, halved reload of three
    wr(gsc_ctl_pkg::IDX_MODE, 8'h60);
    wr(gsc_ctl_pkg::IDX_IFS, 8'h06);
    rd("ifs_idle", gsc_ctl_pkg::IDX_IFS, 8'h00);
    tx_frame_done <= 1'b1;
    @(posedge pclk);
    tx_frame_done <= 1'b0;
    wt(3);
    chk("busy", {7'h0, ifs_busy}, 8'h01);
    chk("bk_hold", {7'h0, backoff_permit}, 8'h00);
    rd("ifs_start", gsc_ctl_pkg::IDX_IFS, 8'h07);
    station.bits(1);
    wt(6);
    rd("ifs_step", gsc_ctl_pkg::IDX_IFS, 8'h05);
    station.bits(2);
    wt(6);
    rd("ifs_pass2", gsc_ctl_pkg::IDX_IFS, 8'h06);
    station.bits(3);
    wt(6);
    rd("ifs_end", gsc_ctl_pkg::IDX_IFS, 8'h00);
    chk("bk_free", {7'h0, backoff_permit}, 8'h01);
  endtask
  task automatic t_carrier();
    // Carrier return in the second pass, first random then deterministic
    tx_frame_done <= 1'b1;
    @(posedge pclk);
    tx_frame_done <= 1'b0;
    station.bits(4);
    wt(6);
    rd("ifs_pass2b", gsc_ctl_pkg::IDX_IFS, 8'h04);
    station.carrier();
    wt(6);
    rd("ifs_restart", gsc_ctl_pkg::IDX_IFS, 8'h07);
    wr(gsc_ctl_pkg::IDX_RAND, gsc_ctl_pkg::RAND_FROZEN);
    wr(gsc_ctl_pkg::IDX_SLOT, 8'h40);
    station.bits(4);
    wt(6);
    station.carrier();
    wt(6);
    rd("ifs_no_restart", gsc_ctl_pkg::IDX_IFS, 8'h04);
    station.bits(2);
    wt(6);
  endtask
  task automatic t_rand();
    wr(gsc_ctl_pkg::IDX_RAND, gsc_ctl_pkg::RAND_FROZEN);
    rd("rand_frozen", gsc_ctl_pkg::IDX_RAND, gsc_ctl_pkg::RAND_FROZEN);
    chk("rand_out", random_value, gsc_ctl_pkg::RAND_FROZEN);
    wr(gsc_ctl_pkg::IDX_RAND, 8'h5a);
    xfer(1'b0, gsc_ctl_pkg::IDX_RAND, 8'h00);
    r = q;
    xfer(1'b0, gsc_ctl_pkg::IDX_RAND, 8'h00);
    chk("rand_runs", {7'h0, q != r}, 8'h01);
  endtask
  task automatic t_rx();
    int h0;
    wr(gsc_ctl_pkg::IDX_RECEIVER_STATUS, 8'h01);
    wt(1);
    chk("hw_ack", {7'h0, hw_ack_on}, 8'h01);
    // Receiver off, line still watched in CSMA
    h0 = hits;
    station.send(8'h96, 1'b0);
    wt(4);
    chk("watch", {7'h0, hits > h0}, 8'h01);
    wr(gsc_ctl_pkg::IDX_RECEIVER_STATUS, 8'h02);
    station.send(8'ha5, 1'b0);
    station.send(8'h3c, 1'b0);
    wt(4);
    rd("receiver_status_data", gsc_ctl_pkg::IDX_RECEIVER_STATUS, 8'h06);
    rd("fifo0", gsc_ctl_pkg::IDX_FIFO, 8'ha5);
    rd("fifo1", gsc_ctl_pkg::IDX_FIFO, 8'h3c);
    wt(12);
    rd("receiver_status_empty", gsc_ctl_pkg::IDX_RECEIVER_STATUS, 8'h02);
    station.send(8'hc3, 1'b0);
    wt(4);
    rx_events <= gsc_ctl_pkg::rx_events_t'(4'b1000);
    @(posedge pclk);
    rx_events <= '0;
    wt(2);
    rd("receiver_status_done", gsc_ctl_pkg::IDX_RECEIVER_STATUS, 8'h0c);
    wr(gsc_ctl_pkg::IDX_RECEIVER_STATUS, 8'h02);
    rd("receiver_status_clr", gsc_ctl_pkg::IDX_RECEIVER_STATUS, 8'h02);
    // External clock selected: a byte on the internal clock must be ignored
    wr(gsc_ctl_pkg::IDX_OPTIONS, 8'h08);
    station.send(8'h69, 1'b0);
    station.send(8'h5c, 1'b1);
    wt(4);
    rd("fifo_ext", gsc_ctl_pkg::IDX_FIFO, 8'h5c);
  endtask

  // ==========================================================
  // Sequence and watchdog
  initial begin
    wt(3);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("rand_rst", random_value, gsc_ctl_pkg::RAND_RESET);
    t_slot();
    t_modes();
    t_ifs();
    t_carrier();
    t_rand();
    t_rx();
    conclude();
  end
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule
